// ### hw/mtp_pkg.sv
package mtp_pkg;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PINS  = 4;
  typedef enum logic [1:0] {MTP_NORMAL, MTP_COMP_PWM, MTP_RSYNC_PWM} mtp_mode_e;

  localparam logic [7:0] OFS_START    = 8'h00;
  localparam logic [7:0] OFS_START_A  = 8'h04;
  localparam logic [7:0] OFS_START_B  = 8'h08;
  localparam logic [7:0] OFS_MODE     = 8'h0c;
  localparam logic [7:0] OFS_OLC1     = 8'h10;
  localparam logic [7:0] OFS_OLC2     = 8'h14;
  localparam logic [7:0] OFS_GCA4     = 8'h18;
  localparam logic [7:0] OFS_GCA7     = 8'h1c;
  localparam logic [7:0] OFS_PERIOD   = 8'h20;
  localparam logic [7:0] OFS_ADCA4    = 8'h24;
  localparam logic [7:0] OFS_ADCB4    = 8'h28;
  localparam logic [7:0] OFS_ADCA7    = 8'h2c;
  localparam logic [7:0] OFS_ADCB7    = 8'h30;
  localparam logic [7:0] OFS_HIZ1     = 8'h34;
  localparam logic [7:0] OFS_HIZ2     = 8'h38;
  localparam logic [7:0] OFS_PFS      = 8'h3c;
  localparam logic [7:0] OFS_INT_STAT = 8'h40;
  localparam logic [7:0] OFS_INT_MASK = 8'h44;
  localparam logic [7:0] OFS_PIN_STAT = 8'h48;

  localparam int unsigned MODE1_LSB = 8;
  localparam int unsigned INT_TRIG4 = 0;
  localparam int unsigned INT_TRIG7 = 1;
  localparam int unsigned INT_ADC4  = 2;
  localparam int unsigned INT_ADC7  = 3;
  localparam int unsigned INT_HIZ   = 4;
  localparam int unsigned INT_W     = 5;

  localparam logic [CNT_W-1:0] PERIOD_RST = 16'hffff;
  localparam logic [CNT_W-1:0] CMP_RST    = 16'hffff;
  localparam logic [PINS-1:0]  PFS_RST    = 4'hf;
endpackage : mtp_pkg

// ### hw/mtp_pair.sv
`timescale 1ns/10ps
module mtp_pair #(
  parameter int unsigned W = 16
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              run_lead,
  input  wire logic              run_main,
  input  wire mtp_pkg::mtp_mode_e mode,
  input  wire logic [W-1:0]      period,
  input  wire logic [W-1:0]      gen_cmp_a,
  input  wire logic [W-1:0]      conv_cmp_a,
  input  wire logic [W-1:0]      conv_cmp_b,
  input  wire logic [1:0]        init_level,
  output logic [1:0]             pin_level,
  output logic                   cmp_trig,
  output logic                   conv_trig
);
  import mtp_pkg::*;

  typedef struct packed {
    logic [W-1:0] lead_cnt;
    logic [W-1:0] main_cnt;
    logic [W-1:0] sub_cnt;
    logic [1:0]   lvl;
    logic         trig;
    logic         conv;
  } mtp_pair_s;

  mtp_pair_s st;
  mtp_pair_s next_st;
  logic      pwm_mode;
  logic      m_own;
  logic      m_other;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st  = st;
    pwm_mode = (mode == MTP_COMP_PWM) || (mode == MTP_RSYNC_PWM);
    m_own    = run_main && (st.main_cnt == gen_cmp_a);
    // complementary mode compares compare-a against the lead and sub counters too
    m_other  = (mode == MTP_COMP_PWM) && run_main &&
               ((st.lead_cnt == gen_cmp_a) || (st.sub_cnt == gen_cmp_a));
    next_st.trig = m_own || m_other;
    next_st.conv = run_main && ((st.main_cnt == conv_cmp_a) ||
                                (st.main_cnt == conv_cmp_b));
    if (run_lead) begin
      next_st.lead_cnt = (st.lead_cnt >= period) ? '0 : st.lead_cnt + 1'b1;
    end
    if (run_main) begin
      next_st.main_cnt = (st.main_cnt >= period) ? '0 : st.main_cnt + 1'b1;
      next_st.sub_cnt  = (st.sub_cnt == '0) ? period : st.sub_cnt - 1'b1;
    end
    if (!run_main) begin
      if (pwm_mode) begin
        next_st.lvl = init_level;
      end else begin
        next_st.lvl = st.lvl;
      end
    end else if (pwm_mode) begin
      if (st.main_cnt == '0) begin
        next_st.lvl = 2'b01;
      end else if (m_own || m_other) begin
        next_st.lvl = 2'b10;
      end
    end else if (m_own) begin
      next_st.lvl = ~st.lvl;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_level = st.lvl;
  assign cmp_trig  = st.trig;
  assign conv_trig = st.conv;
endmodule : mtp_pair

// ### hw/mtp_top.sv
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module mtp_top #(
  parameter int unsigned W = mtp_pkg::CNT_W
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 hiz_request,
  output logic [mtp_pkg::PINS-1:0]  timer_io_pin_out,
  output logic [mtp_pkg::PINS-1:0]  timer_io_pin_oe,
  output logic                      ch_four_compare_trigger,
  output logic                      ch_seven_compare_trigger,
  output logic                      conv_start_trigger_4,
  output logic                      conv_start_trigger_7,
  output logic                      irq
);
  import mtp_pkg::*;

  typedef struct packed {
    logic [3:0]        run;
    mtp_mode_e         mode0;
    mtp_mode_e         mode1;
    logic [1:0]        olc1;
    logic [1:0]        olc2;
    logic [W-1:0]      gca4;
    logic [W-1:0]      gca7;
    logic [W-1:0]      period;
    logic [W-1:0]      adca4;
    logic [W-1:0]      adcb4;
    logic [W-1:0]      adca7;
    logic [W-1:0]      adcb7;
    logic              hiz1;
    logic              hiz2;
    logic [PINS-1:0]   pfs;
    logic [INT_W-1:0]  int_stat;
    logic [INT_W-1:0]  int_mask;
    logic [1:0]        hiz_prev;
    logic [31:0]       rdata;
    logic              err;
  } mtp_top_s;

  mtp_top_s          st;
  mtp_top_s          next_st;
  logic [1:0]        lvl0;
  logic [1:0]        lvl1;
  logic              trg4;
  logic              trg7;
  logic              adc4;
  logic              adc7;
  logic [1:0]        hiz_act;
  logic              setup;
  logic              wr_acc;
  logic              hit;
  logic [31:0]       rd;
  logic [INT_W-1:0]  evt;
  logic [PINS-1:0]   pin_float;

  ////////////////////////////////////////////////////////////////////////
  mtp_pair #(.W(W)) u_pair0 (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .run_lead   (st.run[0]),
    .run_main   (st.run[1]),
    .mode       (st.mode0),
    .period     (st.period),
    .gen_cmp_a  (st.gca4),
    .conv_cmp_a (st.adca4),
    .conv_cmp_b (st.adcb4),
    .init_level (st.olc1),
    .pin_level  (lvl0),
    .cmp_trig   (trg4),
    .conv_trig  (adc4)
  );

  mtp_pair #(.W(W)) u_pair1 (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .run_lead   (st.run[2]),
    .run_main   (st.run[3]),
    .mode       (st.mode1),
    .period     (st.period),
    .gen_cmp_a  (st.gca7),
    .conv_cmp_a (st.adca7),
    .conv_cmp_b (st.adcb7),
    .init_level (st.olc2),
    .pin_level  (lvl1),
    .cmp_trig   (trg7),
    .conv_trig  (adc7)
  );

  ////////////////////////////////////////////////////////////////////////
  // pins float whenever control is enabled and the request stands
  assign hiz_act   = {st.hiz2 && hiz_request, st.hiz1 && hiz_request};
  assign pin_float = {{2{hiz_act[1]}}, {2{hiz_act[0]}}};
  assign timer_io_pin_out = {lvl1, lvl0};
  // function select does not shield a pin from floating
  assign timer_io_pin_oe  = st.pfs & ~pin_float;

  assign ch_four_compare_trigger  = trg4;
  assign ch_seven_compare_trigger = trg7;
  assign conv_start_trigger_4     = adc4;
  assign conv_start_trigger_7     = adc7;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    setup  = psel && !penable;
    wr_acc = psel && penable && pwrite;
    hit    = 1'b1;
    rd     = '0;
    case (paddr)
      OFS_START:    rd[3:0] = st.run;
      OFS_START_A:  rd[1:0] = st.run[1:0];
      OFS_START_B:  rd[1:0] = st.run[3:2];
      OFS_MODE: begin
        rd[1:0]                 = st.mode0;
        rd[MODE1_LSB+1:MODE1_LSB] = st.mode1;
      end
      OFS_OLC1:     rd[1:0] = st.olc1;
      OFS_OLC2:     rd[1:0] = st.olc2;
      OFS_GCA4:     rd[W-1:0] = st.gca4;
      OFS_GCA7:     rd[W-1:0] = st.gca7;
      OFS_PERIOD:   rd[W-1:0] = st.period;
      OFS_ADCA4:    rd[W-1:0] = st.adca4;
      OFS_ADCB4:    rd[W-1:0] = st.adcb4;
      OFS_ADCA7:    rd[W-1:0] = st.adca7;
      OFS_ADCB7:    rd[W-1:0] = st.adcb7;
      OFS_HIZ1:     rd[0] = st.hiz1;
      OFS_HIZ2:     rd[0] = st.hiz2;
      OFS_PFS:      rd[PINS-1:0] = st.pfs;
      OFS_INT_STAT: rd[INT_W-1:0] = st.int_stat;
      OFS_INT_MASK: rd[INT_W-1:0] = st.int_mask;
      OFS_PIN_STAT: rd[7:0] = {2'b00, hiz_act, lvl1, lvl0};
      default:      hit = 1'b0;
    endcase
  end

  always_comb begin
    next_st = st;
    evt     = '0;
    evt[INT_TRIG4] = trg4;
    evt[INT_TRIG7] = trg7;
    evt[INT_ADC4]  = adc4;
    evt[INT_ADC7]  = adc7;
    evt[INT_HIZ]   = |(hiz_act & ~st.hiz_prev);
    next_st.hiz_prev = hiz_act;
    if (setup) begin
      next_st.rdata = rd;
      next_st.err   = !hit;
    end
    if (wr_acc && hit) begin
      case (paddr)
        OFS_START:    next_st.run = pwdata[3:0];
        OFS_START_A:  next_st.run[1:0] = pwdata[1:0];
        OFS_START_B:  next_st.run[3:2] = pwdata[1:0];
        OFS_MODE: begin
          next_st.mode0 = mtp_mode_e'(pwdata[1:0]);
          next_st.mode1 = mtp_mode_e'(pwdata[MODE1_LSB+1:MODE1_LSB]);
        end
        OFS_OLC1:     next_st.olc1 = pwdata[1:0];
        OFS_OLC2:     next_st.olc2 = pwdata[1:0];
        OFS_GCA4:     next_st.gca4 = pwdata[W-1:0];
        OFS_GCA7:     next_st.gca7 = pwdata[W-1:0];
        OFS_PERIOD:   next_st.period = pwdata[W-1:0];
        OFS_ADCA4:    next_st.adca4 = pwdata[W-1:0];
        OFS_ADCB4:    next_st.adcb4 = pwdata[W-1:0];
        OFS_ADCA7:    next_st.adca7 = pwdata[W-1:0];
        OFS_ADCB7:    next_st.adcb7 = pwdata[W-1:0];
        OFS_HIZ1:     next_st.hiz1 = pwdata[0];
        OFS_HIZ2:     next_st.hiz2 = pwdata[0];
        OFS_PFS:      next_st.pfs = pwdata[PINS-1:0];
        OFS_INT_STAT: next_st.int_stat = st.int_stat & ~pwdata[INT_W-1:0];
        OFS_INT_MASK: next_st.int_mask = pwdata[INT_W-1:0];
        default:      next_st.err = st.err;
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_st.int_stat = next_st.int_stat | evt;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st        <= '0;
      st.mode0  <= MTP_NORMAL;
      st.mode1  <= MTP_NORMAL;
      st.gca4   <= CMP_RST;
      st.gca7   <= CMP_RST;
      st.period <= PERIOD_RST;
      st.adca4  <= CMP_RST;
      st.adcb4  <= CMP_RST;
      st.adca7  <= CMP_RST;
      st.adcb7  <= CMP_RST;
      st.pfs    <= PFS_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata  = st.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && st.err;
  assign irq     = |(st.int_stat & st.int_mask);
endmodule : mtp_top

// ### test/mtp_gate_model.sv
`timescale 1ns/10ps
module mtp_gate_model import mtp_pkg::*; (
  input  wire logic [PINS-1:0] pin_out,
  input  wire logic [PINS-1:0] pin_oe,
  output logic      [PINS-1:0] gate
);
  // a floated pin is pulled down at the gate driver input
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      gate[i] = pin_oe[i] ? pin_out[i] : 1'b0;
    end
  end
endmodule : mtp_gate_model

// ### test/mtp_monitor.sv
`timescale 1ns/10ps
module mtp_monitor import mtp_pkg::*; (
  input wire logic            core_clk,
  input wire logic            rst_n,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            hiz_request,
  input wire logic [PINS-1:0] timer_io_pin_out,
  input wire logic [PINS-1:0] timer_io_pin_oe,
  input wire logic            ch_four_compare_trigger,
  input wire logic            ch_seven_compare_trigger,
  input wire logic            conv_start_trigger_4,
  input wire logic            conv_start_trigger_7,
  input wire logic            irq
);
  wire logic any_trig = ch_four_compare_trigger | ch_seven_compare_trigger |
                        conv_start_trigger_4 | conv_start_trigger_7;
  wire logic wr_acc = psel & penable & pwrite;
  default clocking cb @(posedge core_clk); endclocking
  property p_rst_pins;
    !rst_n |=> timer_io_pin_out == '0 && !irq;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins or irq set in reset");
  property p_rst_trig;
    !rst_n |=> !any_trig;
  endproperty
  a_rst_trig: assert property (p_rst_trig) else $error("trigger in reset");
  property p_rst_oe;
    !rst_n |=> timer_io_pin_oe == PFS_RST;
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("enables wrong after reset");
  property p_ready;
    disable iff (!rst_n) psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access phase stalled");
  property p_err;
    disable iff (!rst_n) pslverr |-> psel && penable;
  endproperty
  a_err: assert property (p_err) else $error("error outside access");
  // every word from the first register to the pin status word is mapped
  property p_err_map;
    disable iff (!rst_n) psel && penable && paddr <= OFS_PIN_STAT && paddr[1:0] == 2'b00
      |-> !pslverr;
  endproperty
  a_err_map: assert property (p_err_map) else $error("error on mapped register");
  property p_irq_hold;
    disable iff (!rst_n) irq && !wr_acc |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without write");
  property p_irq_cause;
    disable iff (!rst_n) $rose(irq) |-> any_trig || $past(any_trig) || $past(wr_acc) ||
      $past(hiz_request);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without event");
  c_trig4: cover property (ch_four_compare_trigger);
  c_err: cover property (pslverr);
  c_hiz: cover property (hiz_request && timer_io_pin_oe != PFS_RST);
endmodule : mtp_monitor
bind mtp_top mtp_monitor u_mtp_monitor (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .hiz_request(hiz_request), .timer_io_pin_out(timer_io_pin_out),
  .timer_io_pin_oe(timer_io_pin_oe), .ch_four_compare_trigger(ch_four_compare_trigger),
  .ch_seven_compare_trigger(ch_seven_compare_trigger),
  .conv_start_trigger_4(conv_start_trigger_4),
  .conv_start_trigger_7(conv_start_trigger_7), .irq(irq));

// ### test/mtp_top_bench.sv
`timescale 1ns/10ps
module mtp_top_bench;
  import mtp_pkg::*;
  logic            core_clk;
  logic            rst_n       = 1'b0;
  logic            psel        = 1'b0;
  logic            penable     = 1'b0;
  logic            pwrite      = 1'b0;
  logic            hiz_request = 1'b0;
  logic [7:0]      paddr       = 8'h00;
  logic [31:0]     pwdata      = 32'h0;
  logic [31:0]     prdata, rd;
  logic            pready, pslverr, err, t4, t7, c4, c7, irq;
  logic [PINS-1:0] pin_out, pin_oe, gate, held;
  logic [15:0]     lfsr = 16'h2334;
  logic [15:0]     per, cmp;
  int              miscompares = 0;
  int              n_tests = 0;
  int              n_t4 = 0, n_t7 = 0, n_c4 = 0, s4, s7, sc;
  logic [7:0]      ra [5] = '{OFS_PERIOD, OFS_GCA4, OFS_ADCB7, OFS_PFS, OFS_MODE};
  logic [31:0]     rv [5] = '{32'(PERIOD_RST), 32'(CMP_RST), 32'(CMP_RST), 32'(PFS_RST), 32'h0};

  mtp_top u_mtp_top (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hiz_request(hiz_request), .timer_io_pin_out(pin_out),
    .timer_io_pin_oe(pin_oe), .ch_four_compare_trigger(t4), .ch_seven_compare_trigger(t7),
    .conv_start_trigger_4(c4), .conv_start_trigger_7(c7), .irq(irq));
  mtp_gate_model u_mtp_gate_model (.pin_out(pin_out), .pin_oe(pin_oe), .gate(gate));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (t4 === 1'b1) n_t4 <= n_t4 + 1;
    if (t7 === 1'b1) n_t7 <= n_t7 + 1;
    if (c4 === 1'b1 && c7 === 1'b1) n_c4 <= n_c4 + 1;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  function automatic int hits(input int periods, input int per_period);
    return periods * per_period;
  endfunction : hits
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, ra[i], 32'h0);
      check("reset value", rd, rv[i]);
    end
    xfer(1'b0, 8'h80, 32'h0);
    check("unmapped error", 32'(err), 32'h1);
    lfsr = nxt(lfsr);
    per = 16'h10 + 16'(lfsr[3:0]);
    lfsr = nxt(lfsr);
    cmp = 16'h4 + 16'(lfsr[1:0]);
    xfer(1'b1, OFS_PERIOD, 32'(per));
    xfer(1'b1, OFS_GCA4, 32'(cmp));
    xfer(1'b1, OFS_GCA7, 32'(cmp));
    xfer(1'b1, OFS_ADCA4, 32'h2);
    xfer(1'b1, OFS_ADCA7, 32'h2);
    xfer(1'b1, OFS_OLC1, 32'h2);
    xfer(1'b1, OFS_OLC2, 32'h1);
    xfer(1'b1, OFS_MODE, (32'(MTP_COMP_PWM) << MODE1_LSB) | 32'(MTP_COMP_PWM));
    xfer(1'b1, OFS_START, 32'h5);
    xfer(1'b1, OFS_START, 32'hf);
    repeat (8) @(posedge core_clk);
    s4 = n_t4;
    s7 = n_t7;
    sc = n_c4;
    repeat (4 * (per + 1)) @(posedge core_clk);
    check("trig4 count", 32'(n_t4 - s4), 32'(hits(4, 3)));
    check("trig7 count", 32'(n_t7 - s7), 32'(hits(4, 3)));
    check("conv count", 32'(n_c4 - sc), 32'(hits(4, 1)));
    xfer(1'b1, OFS_START, 32'h0);
    repeat (per + 1) @(posedge core_clk);
    check("stop level", 32'(gate), 32'h6);
    // reset-synchronised mode with swapped initial levels
    xfer(1'b1, OFS_OLC1, 32'h1);
    xfer(1'b1, OFS_OLC2, 32'h2);
    xfer(1'b1, OFS_MODE, (32'(MTP_RSYNC_PWM) << MODE1_LSB) | 32'(MTP_RSYNC_PWM));
    xfer(1'b1, OFS_START, 32'hf);
    repeat (per + 1) @(posedge core_clk);
    xfer(1'b1, OFS_START, 32'h0);
    repeat (2) @(posedge core_clk);
    check("rsync stop level", 32'(gate), 32'h9);
    xfer(1'b1, OFS_MODE, 32'h0);
    xfer(1'b1, OFS_START_A, 32'h3);
    xfer(1'b1, OFS_START_B, 32'h3);
    lfsr = nxt(lfsr);
    repeat (5 + lfsr[4:0]) @(posedge core_clk);
    xfer(1'b1, OFS_START_A, 32'h0);
    xfer(1'b1, OFS_START_B, 32'h0);
    repeat (2) @(posedge core_clk);
    held = gate;
    // initial levels that differ from the held ones expose a wrong reload
    xfer(1'b1, OFS_OLC1, 32'(~held[1:0]));
    xfer(1'b1, OFS_OLC2, 32'(~held[3:2]));
    repeat (per + 1) @(posedge core_clk);
    check("held level", 32'(gate), 32'(held));
    xfer(1'b1, OFS_INT_MASK, 32'h0);
    xfer(1'b1, OFS_PFS, 32'hf);
    xfer(1'b1, OFS_HIZ1, 32'h1);
    hiz_request <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("float enables", 32'(pin_oe), 32'hc);
    check("float gate", 32'(gate[1:0]), 32'h0);
    check("masked irq", 32'(irq), 32'h0);
    xfer(1'b1, OFS_INT_MASK, 32'h1 << INT_HIZ);
    hiz_request <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("irq raised", 32'(irq), 32'h1);
    xfer(1'b1, OFS_INT_STAT, 32'h1 << INT_HIZ);
    repeat (2) @(posedge core_clk);
    check("irq cleared", 32'(irq), 32'h0);
    // reset after the timers are stopped returns written registers to their initial values
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    xfer(1'b0, OFS_PERIOD, 32'h0);
    check("period after reset", rd, 32'(PERIOD_RST));
    check("pins after reset", 32'(pin_out), 32'h0);
    conclude();
  end
endmodule : mtp_top_bench
